// *** ssp_pkg.sv ***
// shared constants, encodings and carriers for the subtract/shift/pointer/stop unit
package ssp_pkg;
    // opcodes
    localparam logic [7:0] OP_SEL_BANK_ONE = 8'h5F;
    localparam logic [7:0] OP_SEL_BANK_ZERO = 8'h4F;
    localparam logic [7:0] OP_FORCE_CARRY = 8'hDF;
    localparam logic [7:0] OP_STOP = 8'h7F;
    localparam logic [7:0] OP_LOAD_POINTERS = 8'h31;
    localparam logic [7:0] OP_SHIFT_DIRECT = 8'hD0;
    localparam logic [7:0] OP_SHIFT_INDIRECT = 8'hD1;
    localparam logic [3:0] OP_HI_SUB = 4'h2;
    localparam logic [3:0] OP_HI_SUB_BORROW = 4'h3;
    localparam logic [3:0] OP_LO_RR = 4'h2;
    localparam logic [3:0] OP_LO_RIR = 4'h3;
    localparam logic [3:0] OP_LO_REG_REG = 4'h4;
    localparam logic [3:0] OP_LO_REG_IND = 4'h5;
    localparam logic [3:0] OP_LO_REG_IMM = 4'h6;
    // instruction timing and length
    localparam logic [2:0] CYC_SHORT = 3'h4;
    localparam logic [2:0] CYC_LONG = 3'h6;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    // condition-code register layout; bank bit fixed at 0
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int FL_D = 3;
    localparam int FL_H = 2;
    localparam int FL_BANK = 0;
    // register-file addresses seen on the register port
    localparam logic [7:0] ADDR_PTR_ZERO = 8'hD6;
    localparam logic [7:0] ADDR_PTR_ONE = 8'hD7;
    localparam logic [7:0] ADDR_FLAGS = 8'hDE;
    localparam logic [7:0] ADDR_STATUS = 8'hDF;
    // reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_PTR_ZERO = 8'h00;
    localparam logic [7:0] RST_PTR_ONE = 8'h08;
    // set 1 bank 1 present in this build
    localparam logic BANK1_PRESENT = 1'b1;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_EXEC = 2'b01,
        SSP_STOP = 2'b10
    } ssp_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } ssp_req_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } ssp_wr_t;

    function automatic logic [2:0] op_cycles(input logic [7:0] op);
        op_cycles = (op[7:4] inside {OP_HI_SUB, OP_HI_SUB_BORROW} && op[3:0] inside {[OP_LO_RIR:OP_LO_REG_IMM]})
            ? CYC_LONG : CYC_SHORT;
    endfunction

    function automatic logic [1:0] op_length(input logic [7:0] op);
        if (op[7:4] inside {OP_HI_SUB, OP_HI_SUB_BORROW} && op[3:0] >= OP_LO_REG_REG)
            op_length = LEN_THREE;
        else if (op inside {OP_SEL_BANK_ONE, OP_SEL_BANK_ZERO, OP_FORCE_CARRY, OP_STOP})
            op_length = LEN_ONE;
        else
            op_length = LEN_TWO;
    endfunction

    // working register nibble to full register address through the window pointers
    function automatic logic [7:0] work_addr(input logic [3:0] nib, input logic [7:0] p0, input logic [7:0] p1);
        work_addr = nib[3] ? {p1[7:3], nib[2:0]} : {p0[7:3], nib[2:0]};
    endfunction
endpackage

// *** ssp_sub.sv ***
// 8-bit subtractor with borrow input and its flag terms
`timescale 1ns/100ps
module ssp_sub (
    input wire logic [7:0] dst,
    input wire logic [7:0] src,
    input wire logic cin,
    output logic [7:0] res,
    output logic borrow,
    output logic zero,
    output logic neg,
    output logic ovf,
    output logic half
);
    logic [8:0] full;
    logic [4:0] low;
    // two's complement add: dst + ~src + !cin, borrow is the missing carry
    assign full = {1'b0, dst} + {1'b0, ~src} + {8'h00, ~cin};
    assign low = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, ~cin};
    assign res = full[7:0];
    assign borrow = ~full[8];
    assign zero = (full[7:0] == 8'h00);
    assign neg = full[7];
    assign ovf = (dst[7] ^ src[7]) & (full[7] == src[7]);
    assign half = ~low[4];
endmodule // ssp_sub

// *** ssp_sra.sv ***
// arithmetic right shift by one with flag terms
`timescale 1ns/100ps
module ssp_sra (
    input wire logic [7:0] din,
    output logic [7:0] res,
    output logic cout,
    output logic zero,
    output logic neg
);
    assign res = {din[7], din[7:1]};
    assign cout = din[0];
    assign zero = (din[7:1] == 7'h00) && !din[7];
    assign neg = din[7];
endmodule // ssp_sra

// *** ssp_core.sv ***
// execution unit for bank select, subtracts, carry set, shift, pointer load and stop
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ssp_core (
    input wire logic clk,
    input wire logic nrst,
    input ssp_pkg::ssp_req_t req,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] ind_addr,
    input wire logic ext_irq,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic rdy,
    output logic done,
    output logic unsupported,
    output logic [1:0] len_bytes,
    output ssp_pkg::ssp_wr_t wr,
    output logic [7:0] flags,
    output logic [7:0] window_pointer_zero,
    output logic [7:0] window_pointer_one,
    output logic bank_sel,
    output logic stop_mode,
    output logic cpu_clk_en,
    output logic sys_clk_en
);
    ssp_pkg::ssp_state_t state;
    logic [2:0] cnt;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] dv;
    logic [7:0] sv;
    logic [7:0] ia;
    logic issue;
    logic finish;
    // port writes are held off in stop so retained state cannot move
    logic flags_wr;
    logic ptr0_wr;
    logic ptr1_wr;

    // datapath terms
    logic is_sub;
    logic [7:0] sub_src;
    logic [7:0] sub_res;
    logic sub_c;
    logic sub_z;
    logic sub_s;
    logic sub_v;
    logic sub_h;
    logic [7:0] sh_res;
    logic sh_c;
    logic sh_z;
    logic sh_s;

    // decoded effects of the latched instruction
    logic [7:0] next_flags;
    logic [7:0] next_ptr0;
    logic [7:0] next_ptr1;
    logic next_wr_en;
    logic [7:0] next_wr_addr;
    logic [7:0] next_wr_data;
    logic next_unsup;
    logic next_stop;

    assign issue = (state == ssp_pkg::SSP_IDLE) && req.valid;
    assign finish = (state == ssp_pkg::SSP_EXEC) && (cnt == 3'h1);
    assign flags_wr = bus_wr && !stop_mode && (bus_addr == ssp_pkg::ADDR_FLAGS);
    assign ptr0_wr = bus_wr && !stop_mode && (bus_addr == ssp_pkg::ADDR_PTR_ZERO);
    assign ptr1_wr = bus_wr && !stop_mode && (bus_addr == ssp_pkg::ADDR_PTR_ONE);
    assign is_sub = (op[7:4] == ssp_pkg::OP_HI_SUB || op[7:4] == ssp_pkg::OP_HI_SUB_BORROW)
        && op[3:0] >= ssp_pkg::OP_LO_RR && op[3:0] <= ssp_pkg::OP_LO_REG_IMM;
    // immediate form takes the source from the instruction stream
    assign sub_src = (op[3:0] == ssp_pkg::OP_LO_REG_IMM) ? b2 : sv;

    ssp_sub u_sub (
        .dst(dv),
        .src(sub_src),
        .cin((op[7:4] == ssp_pkg::OP_HI_SUB_BORROW) & flags[ssp_pkg::FL_C]),
        .res(sub_res),
        .borrow(sub_c),
        .zero(sub_z),
        .neg(sub_s),
        .ovf(sub_v),
        .half(sub_h)
    );

    ssp_sra u_sra (
        .din(dv),
        .res(sh_res),
        .cout(sh_c),
        .zero(sh_z),
        .neg(sh_s)
    );

    always_comb begin
        next_flags = flags;
        next_ptr0 = window_pointer_zero;
        next_ptr1 = window_pointer_one;
        next_wr_en = 1'b0;
        next_wr_addr = 8'h00;
        next_wr_data = 8'h00;
        next_unsup = 1'b0;
        next_stop = 1'b0;
        if (is_sub) begin
            next_flags[ssp_pkg::FL_C] = sub_c;
            next_flags[ssp_pkg::FL_V] = sub_v;
            next_flags[ssp_pkg::FL_Z] = sub_z;
            next_flags[ssp_pkg::FL_S] = sub_s;
            next_flags[ssp_pkg::FL_D] = 1'b1;
            next_flags[ssp_pkg::FL_H] = sub_h;
            next_wr_en = 1'b1;
            next_wr_data = sub_res;
            // packed forms name dst in the high nibble; register-register puts dst second
            case (op[3:0])
                ssp_pkg::OP_LO_RR: next_wr_addr = ssp_pkg::work_addr(b1[7:4], window_pointer_zero, window_pointer_one);
                ssp_pkg::OP_LO_RIR: next_wr_addr = ssp_pkg::work_addr(b1[7:4], window_pointer_zero, window_pointer_one);
                ssp_pkg::OP_LO_REG_REG: next_wr_addr = b2;
                ssp_pkg::OP_LO_REG_IND: next_wr_addr = b2;
                default: next_wr_addr = b1;
            endcase
        end else begin
            case (op)
                ssp_pkg::OP_SEL_BANK_ONE: next_flags[ssp_pkg::FL_BANK] = 1'b1;
                ssp_pkg::OP_SEL_BANK_ZERO: next_flags[ssp_pkg::FL_BANK] = 1'b0;
                ssp_pkg::OP_FORCE_CARRY: next_flags[ssp_pkg::FL_C] = 1'b1;
                ssp_pkg::OP_SHIFT_DIRECT, ssp_pkg::OP_SHIFT_INDIRECT: begin
                    next_flags[ssp_pkg::FL_C] = sh_c;
                    next_flags[ssp_pkg::FL_Z] = sh_z;
                    next_flags[ssp_pkg::FL_S] = sh_s;
                    next_flags[ssp_pkg::FL_V] = 1'b0;
                    next_wr_en = 1'b1;
                    next_wr_data = sh_res;
                    // indirect form writes where the named register points
                    next_wr_addr = (op == ssp_pkg::OP_SHIFT_INDIRECT) ? ia : b1;
                end
                ssp_pkg::OP_LOAD_POINTERS: begin
                    case (b1[1:0])
                        2'b10: next_ptr0[7:3] = b1[7:3];
                        2'b01: next_ptr1[7:3] = b1[7:3];
                        2'b00: begin
                            next_ptr0 = {b1[7:4], 1'b0, window_pointer_zero[2:0]};
                            next_ptr1 = {b1[7:4], 1'b1, window_pointer_one[2:0]};
                        end
                        // both low bits set selects nothing
                        default: next_unsup = 1'b1;
                    endcase
                end
                ssp_pkg::OP_STOP: next_stop = 1'b1;
                default: next_unsup = 1'b1;
            endcase
        end
    end

    // sequencing: capture, count the documented cycles, commit, maybe stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ssp_pkg::SSP_IDLE;
            cnt <= 3'h0;
            rdy <= 1'b1;
        end else begin
            case (state)
                ssp_pkg::SSP_IDLE: begin
                    if (req.valid) begin
                        state <= ssp_pkg::SSP_EXEC;
                        cnt <= ssp_pkg::op_cycles(req.opcode) - 3'h1;
                        rdy <= 1'b0;
                    end
                end
                ssp_pkg::SSP_EXEC: begin
                    cnt <= cnt - 3'h1;
                    if (finish) begin
                        if (next_stop) begin
                            state <= ssp_pkg::SSP_STOP;
                        end else begin
                            state <= ssp_pkg::SSP_IDLE;
                            rdy <= 1'b1;
                        end
                    end
                end
                ssp_pkg::SSP_STOP: begin
                    // no internal source can reach here; clocks are down
                    if (ext_irq) begin
                        state <= ssp_pkg::SSP_IDLE;
                        rdy <= 1'b1;
                    end
                end
                default: begin
                    state <= ssp_pkg::SSP_IDLE;
                    rdy <= 1'b1;
                end
            endcase
        end
    end

    // clock gating follows the stop state; only the pin interrupt or reset undoes it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stop_mode <= 1'b0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
        end else if (finish && next_stop) begin
            stop_mode <= 1'b1;
            cpu_clk_en <= 1'b0;
            sys_clk_en <= 1'b0;
        end else if (state == ssp_pkg::SSP_STOP && ext_irq) begin
            stop_mode <= 1'b0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
        end
    end

    // instruction and operand capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op <= 8'h00;
            b1 <= 8'h00;
            b2 <= 8'h00;
            dv <= 8'h00;
            sv <= 8'h00;
            ia <= 8'h00;
        end else if (issue) begin
            op <= req.opcode;
            b1 <= req.byte1;
            b2 <= req.byte2;
            dv <= dst_val;
            sv <= src_val;
            ia <= ind_addr;
        end
    end

    // the fetch side counts stop as retired, so done pulses there too
    // completion outputs, one cycle each
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            unsupported <= 1'b0;
            len_bytes <= 2'h0;
            wr <= '0;
        end else begin
            done <= finish;
            unsupported <= finish & next_unsup;
            len_bytes <= finish ? ssp_pkg::op_length(op) : 2'h0;
            wr.en <= finish & next_wr_en;
            wr.addr <= finish ? next_wr_addr : 8'h00;
            wr.data <= finish ? next_wr_data : 8'h00;
        end
    end

    // condition codes: instruction commit wins over a port write in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= ssp_pkg::RST_FLAGS;
        end else if (finish) begin
            flags <= next_flags;
        end else if (flags_wr) begin
            flags <= bus_wdata;
        end
    end

    // bank bit as it will stand after this edge, so bank_sel tracks flags
    function automatic logic next_bank_bit();
        if (finish) begin
            next_bank_bit = next_flags[ssp_pkg::FL_BANK];
        end else if (flags_wr) begin
            next_bank_bit = bus_wdata[ssp_pkg::FL_BANK];
        end else begin
            next_bank_bit = flags[ssp_pkg::FL_BANK];
        end
    endfunction

    // bank select falls back to bank 0 where bank 1 is absent
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bank_sel <= 1'b0;
        end else begin
            bank_sel <= next_bank_bit() & ssp_pkg::BANK1_PRESENT;
        end
    end

    // window pointers, reachable at their register-file addresses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            window_pointer_zero <= ssp_pkg::RST_PTR_ZERO;
            window_pointer_one <= ssp_pkg::RST_PTR_ONE;
        end else if (finish) begin
            window_pointer_zero <= next_ptr0;
            window_pointer_one <= next_ptr1;
        end else begin
            if (ptr0_wr) begin
                window_pointer_zero <= bus_wdata;
            end
            if (ptr1_wr) begin
                window_pointer_one <= bus_wdata;
            end
        end
    end

    // reads stay open in stop so software can see the mode
    // register port reads: data only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            case (bus_addr)
                ssp_pkg::ADDR_PTR_ZERO: bus_rdata <= window_pointer_zero;
                ssp_pkg::ADDR_PTR_ONE: bus_rdata <= window_pointer_one;
                ssp_pkg::ADDR_FLAGS: bus_rdata <= flags;
                ssp_pkg::ADDR_STATUS: bus_rdata <= {5'h00, stop_mode, state};
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end
endmodule // ssp_core

// *** ssp_core_checker.sv ***
// concurrent checks on the ports of the subtract/shift/pointer/stop unit
`timescale 1ns/100ps
module ssp_core_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire ssp_pkg::ssp_req_t req,
    input wire logic [7:0] dst_val,
    input wire logic [7:0] src_val,
    input wire logic ext_irq,
    input wire logic rdy,
    input wire logic done,
    input wire logic [1:0] len_bytes,
    input wire ssp_pkg::ssp_wr_t wr,
    input wire logic [7:0] flags,
    input wire logic [7:0] window_pointer_zero,
    input wire logic [7:0] window_pointer_one,
    input wire logic bank_sel,
    input wire logic stop_mode,
    input wire logic cpu_clk_en,
    input wire logic sys_clk_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic [7:0] cap_op;
    logic [7:0] cap_dst;
    logic [7:0] cap_src;
    logic cap_cin;
    logic [8:0] full;
    logic [4:0] low;
    logic take;
    logic is_sub;
    logic is_shift;
    assign take = req.valid && rdy;
    assign is_sub = cap_op[7:5] == 3'h1 && cap_op[3:0] inside {[4'h2:4'h6]};
    assign is_shift = cap_op[7:1] == 7'h68;
    assign full = {1'h0, cap_dst} - {1'h0, cap_src} - {8'h00, cap_cin};
    assign low = {1'h0, cap_dst[3:0]} - {1'h0, cap_src[3:0]} - {4'h0, cap_cin};
    // operands kept so the result can be judged when done arrives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_op <= 8'h00;
            cap_dst <= 8'h00;
            cap_src <= 8'h00;
            cap_cin <= 1'h0;
        end else if (take) begin
            cap_op <= req.opcode;
            cap_dst <= dst_val;
            cap_src <= src_val;
            cap_cin <= req.opcode[7:4] == ssp_pkg::OP_HI_SUB_BORROW && flags[ssp_pkg::FL_C];
        end
    end
    property p_bank_one;
        take && req.opcode == ssp_pkg::OP_SEL_BANK_ONE |-> ##4 done && len_bytes == 2'h1 && flags[0] && bank_sel;
    endproperty
    a_bank_one: assert property (p_bank_one) else $error("bank one select");
    property p_bank_zero;
        take && req.opcode == ssp_pkg::OP_SEL_BANK_ZERO |-> ##4 done && !flags[0] && !bank_sel;
    endproperty
    a_bank_zero: assert property (p_bank_zero) else $error("bank zero select");
    property p_force_carry;
        take && req.opcode == ssp_pkg::OP_FORCE_CARRY |-> ##4 done && flags[7] && flags[6:0] == $past(flags[6:0], 4);
    endproperty
    a_force_carry: assert property (p_force_carry) else $error("carry force");
    property p_long_time;
        take && req.opcode[7:5] == 3'h1 && req.opcode[3:0] inside {[4'h3:4'h6]} |-> ##1 !done [*5] ##1 done;
    endproperty
    a_long_time: assert property (p_long_time) else $error("six cycle timing");
    property p_short_time;
        take && req.opcode inside {8'h22, 8'h32, 8'hD0, 8'hD1, 8'h31} |-> ##1 !done [*3] ##1 done;
    endproperty
    a_short_time: assert property (p_short_time) else $error("four cycle timing");
    property p_sub_result;
        done && is_sub |-> wr.en && wr.data == full[7:0] && flags[ssp_pkg::FL_C] == full[8] && flags[ssp_pkg::FL_D];
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("subtract result");
    property p_sub_flags;
        done && is_sub |-> flags[ssp_pkg::FL_H] == low[4] && flags[ssp_pkg::FL_Z] == (full[7:0] == 8'h00)
            && flags[ssp_pkg::FL_V] == (cap_dst[7] != cap_src[7] && full[7] == cap_src[7]);
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags");
    property p_sub_len;
        done && is_sub |-> len_bytes == (cap_op[3:0] > 4'h3 ? 2'h3 : 2'h2);
    endproperty
    a_sub_len: assert property (p_sub_len) else $error("subtract length");
    property p_shift;
        done && is_shift |-> wr.data == {cap_dst[7], cap_dst[7:1]} && flags[ssp_pkg::FL_C] == cap_dst[0]
            && !flags[ssp_pkg::FL_V] && flags[3:2] == $past(flags[3:2]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift result");
    property p_ptr_one;
        take && req.opcode == 8'h31 && req.byte1[1:0] == 2'h1 |-> ##4
            window_pointer_one[7:3] == $past(req.byte1[7:3], 4) && window_pointer_zero == $past(window_pointer_zero, 4);
    endproperty
    a_ptr_one: assert property (p_ptr_one) else $error("pointer one load");
    property p_ptr_both;
        take && req.opcode == 8'h31 && req.byte1[1:0] == 2'h0 |-> ##4
            window_pointer_zero[7:3] == {$past(req.byte1[7:4], 4), 1'h0}
            && window_pointer_one[7:3] == {$past(req.byte1[7:4], 4), 1'h1};
    endproperty
    a_ptr_both: assert property (p_ptr_both) else $error("pointer pair load");
    property p_stop_enter;
        take && req.opcode == ssp_pkg::OP_STOP |-> ##4 stop_mode && !cpu_clk_en && !sys_clk_en && done && len_bytes == 2'h1;
    endproperty
    a_stop_enter: assert property (p_stop_enter) else $error("stop entry");
    property p_stop_hold;
        stop_mode && !ext_irq |=> stop_mode && !rdy;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left early");
    property p_stop_wake;
        stop_mode && ext_irq |=> !stop_mode && cpu_clk_en && sys_clk_en && rdy;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop wake");
    c_stop: cover property (take && req.opcode == ssp_pkg::OP_STOP);
    c_back_to_back: cover property (done && req.valid);
    c_wake: cover property (stop_mode && ext_irq);
endmodule // ssp_core_checker

bind ssp_core ssp_core_checker i_ssp_core_checker (.clk(clk), .nrst(nrst), .req(req), .dst_val(dst_val),
    .src_val(src_val), .ext_irq(ext_irq), .rdy(rdy), .done(done), .len_bytes(len_bytes), .wr(wr), .flags(flags),
    .window_pointer_zero(window_pointer_zero), .window_pointer_one(window_pointer_one), .bank_sel(bank_sel),
    .stop_mode(stop_mode), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en));

// *** tb.sv ***
// self-checking bench for the subtract/shift/pointer/stop unit
`timescale 1ns/100ps
module tb;
    // bytes: opcode, byte1, byte2, dst, src, expected addr or ptr0, data or ptr1, flags
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] ea;
        logic [7:0] ed;
        logic [7:0] ef;
    } ssp_row_t;
    localparam int NR = 21;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    ssp_pkg::ssp_req_t req = '0;
    logic [7:0] dst_val = 8'h00;
    logic [7:0] src_val = 8'h00;
    logic [7:0] ind_addr = 8'h00;
    logic ext_irq = 1'h0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'h0;
    logic bus_rd = 1'h0;
    logic [7:0] bus_rdata, flags, window_pointer_zero, window_pointer_one;
    logic rdy, done, unsupported, bank_sel, stop_mode, cpu_clk_en, sys_clk_en;
    logic [1:0] len_bytes;
    ssp_pkg::ssp_wr_t wr;
    int fails = 0;
    int num_checks = 0;
    ssp_row_t rows [NR] = '{64'h5F_00_00_00_00_00_00_01, 64'hDF_00_00_00_00_00_00_81, 64'h32_12_00_10_03_01_0C_0D,
        64'h4F_00_00_00_00_00_00_0C, 64'h31_40_00_00_00_40_48_0C, 64'h22_12_00_12_03_41_0F_0C,
        64'h22_9A_00_80_01_49_7F_1C, 64'h23_13_00_12_0A_41_08_0C, 64'h24_02_01_21_03_01_1E_0C,
        64'h26_01_90_21_90_01_91_B8, 64'h26_01_65_21_65_01_BC_AC, 64'h33_13_00_00_00_41_FF_AC,
        64'h34_02_01_20_03_01_1C_0C, 64'h35_02_01_20_0A_01_16_0C, 64'h36_01_8A_20_8A_01_96_BC,
        64'hD0_00_00_9A_00_00_CD_2C, 64'hD1_02_03_BC_00_03_DE_2C, 64'h31_52_00_00_00_50_48_2C,
        64'h31_69_00_00_00_50_68_2C, 64'h31_43_00_00_00_50_68_2C, 64'h32_F5_00_00_00_6F_00_48};
    always #10 clk = ~clk;
    ssp_core i_ssp_core (.clk(clk), .nrst(nrst), .req(req), .dst_val(dst_val), .src_val(src_val),
        .ind_addr(ind_addr), .ext_irq(ext_irq), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rdy(rdy), .done(done), .unsupported(unsupported),
        .len_bytes(len_bytes), .wr(wr), .flags(flags), .window_pointer_zero(window_pointer_zero),
        .window_pointer_one(window_pointer_one), .bank_sel(bank_sel), .stop_mode(stop_mode),
        .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en));
    task automatic end_of_test();
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'h1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'h0;
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_rd <= 1'h1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'h0;
        #1 chk(bus_rdata, exp);
    endtask
    // drives at the current edge; the caller decides when valid drops
    task automatic issue(input ssp_row_t r);
        req <= '{1'h1, r.op, r.b1, r.b2};
        dst_val <= r.dst;
        src_val <= r.src;
        ind_addr <= r.b2;
    endtask
    task automatic run_op(input logic [7:0] op);
        @(posedge clk);
        issue({op, 56'h0});
        @(posedge clk);
        req.valid <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic chk_idle(input logic [7:0] f, input logic [7:0] a, input logic [7:0] b);
        chk({rdy, stop_mode, cpu_clk_en, sys_clk_en, done}, 5'h16);
        chk({flags, window_pointer_zero, window_pointer_one}, {f, a, b});
    endtask
    task automatic check_row(input ssp_row_t r);
        chk(done, 1'h1);
        chk(len_bytes, (r.op[7:5] == 3'h1 && r.op[3:0] > 4'h3) ? 2'h3 : (r.op[3:0] == 4'hF ? 2'h1 : 2'h2));
        chk(flags, r.ef);
        chk(bank_sel, r.ef[0] & ssp_pkg::BANK1_PRESENT);
        chk(unsupported, r.op == 8'h31 && r.b1[1:0] == 2'h3);
        if (r.op == 8'h31) begin
            chk({window_pointer_zero, window_pointer_one}, {r.ea, r.ed});
        end else if (r.op[3:0] != 4'hF) begin
            chk({wr.en, wr.addr, wr.data}, {1'h1, r.ea, r.ed});
        end
    endtask
    initial begin
        #1000000;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        #1 chk_idle(8'h00, 8'h00, 8'h08);
        @(posedge clk);
        // every row is issued in the done cycle of the one before
        for (int i = 0; i < NR; i++) begin
            issue(rows[i]);
            if (i > 0) begin
                #1 check_row(rows[i - 1]);
            end
            @(posedge clk);
            req.valid <= 1'h0;
            repeat (((rows[i].op[7:5] == 3'h1 && rows[i].op[3:0] inside {[4'h3:4'h6]}) ? 6 : 4) - 1) @(posedge clk);
        end
        #1 check_row(rows[NR - 1]);
        bus_read(8'hD6, 8'h50);
        bus_read(8'hD7, 8'h68);
        bus_read(8'h10, 8'h00);
        bus_write(8'h10, 8'h55);
        bus_write(8'hD6, 8'h20);
        bus_read(8'hD6, 8'h20);
        bus_write(ssp_pkg::ADDR_FLAGS, 8'h7E);
        run_op(ssp_pkg::OP_FORCE_CARRY);
        chk({done, flags}, 9'h1FE);
        run_op(ssp_pkg::OP_STOP);
        chk({stop_mode, cpu_clk_en, sys_clk_en, rdy}, 4'h8);
        bus_read(ssp_pkg::ADDR_STATUS, 8'h06);
        bus_write(ssp_pkg::ADDR_FLAGS, 8'h00);
        @(posedge clk);
        issue(64'h5F00000000000000);
        repeat (4) @(posedge clk);
        req.valid <= 1'h0;
        ext_irq <= 1'h1;
        #1 chk({stop_mode, flags}, 9'h1FE);
        @(posedge clk);
        ext_irq <= 1'h0;
        #1 chk_idle(8'hFE, 8'h20, 8'h68);
        run_op(ssp_pkg::OP_STOP);
        @(posedge clk);
        nrst <= 1'h0;
        // reset held through the oscillator settling time before release
        repeat (6) @(posedge clk);
        chk(stop_mode, 1'h0);
        nrst <= 1'h1;
        #1 chk_idle(8'h00, 8'h00, 8'h08);
        end_of_test();
    end
endmodule // tb
